/* File: rtl/cisp_top.sv */
// Notes on behaviour
// - unconnected shared inputs read as zero
// - shared inputs a, b and d act on all eight configured channels; c drives the one leak flag
// - terminal a high with code 3 selects parameter set 2
// - terminal d high with code 1 selects the second setpoint
// - terminal b high with code 1 switches configured channels off
// - off only forces outputs inactive; ramps and selection keep running
// - leakage input on terminal c with code 4 always monitored
// - a state switched on by one source is switched off only by it
// - after power loss state comes from stored host command plus inputs
// - at switch-on working setpoint loads stored nonvolatile setpoint
// - rising steps ramp at the rising gradient
// - falling steps ramp at the falling gradient
// - switches to or from setpoint 2 ramp at the switch-over gradient
// - second setpoint kept across supply loss
// - later switch-overs come from host or terminal d, plus terminal b when CISP_CTRL_TERM14_SP is set and b does not carry the off code
// - setpoint 2 has priority and raises a status flag while effective
// - startup stage picks active setpoint or its own value
// - setpoint clamped to low and high limits before control
`timescale 1ns/100ps
`default_nettype none
`include "cisp_cfg.svh"
module cisp_top #(
  parameter int NCH = 8,
  parameter int SCAN_CYC = `CISP_SCAN_CYC
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // shared terminals, pulled low outside
  input wire logic shared_terminal_a,
  input wire logic shared_terminal_b,
  input wire logic shared_terminal_c,
  input wire logic shared_terminal_d,
  // nonvolatile store image, valid at reset release
  input wire logic [15:0] nv_setpoint,
  input wire logic [15:0] nv_second_setpoint,
  input wire logic [7:0] nv_host_sp2,
  input wire logic [7:0] nv_host_off,
  // per channel results
  output logic [7:0] param_set_select,
  output logic [7:0] setpoint_select,
  output logic [7:0] chan_off,
  output logic leak_alarm,
  // axi4-lite slave
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // byte-lane merge
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (st[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // step a value toward a target by at most gr
  function automatic logic [15:0] ramp(input logic [15:0] cur, input logic [15:0] tgt, input logic [15:0] gr);
    logic [16:0] s;
    s = 17'h00000;
    if (tgt > cur) begin
      s = {1'b0, cur} + {1'b0, gr};
      ramp = (s >= {1'b0, tgt}) ? tgt : s[15:0];
    end else begin
      ramp = ((cur - tgt) <= gr) ? tgt : 16'(cur - gr);
    end
  endfunction

  // three-stage input synchronisers
  logic [3:0] s1_r, s2_r, s3_r;
  cisp_pkg::cisp_term_t term_r;
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      s1_r <= 4'h0;
      s2_r <= 4'h0;
      s3_r <= 4'h0;
    end else begin
      s1_r <= {shared_terminal_a, shared_terminal_b, shared_terminal_c, shared_terminal_d};
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end
  // accept a level once stages two and three agree; idle level is zero
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      term_r <= '0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (s2_r[i] == s3_r[i]) begin
          term_r[i] <= s3_r[i];
        end
      end
    end
  end

  // registers
  logic [31:0] ctrl_r;
  logic [2:0] chsel_r;
  logic [7:0] chcfg_r [NCH];
  cisp_pkg::cisp_chan_t ch_r [NCH];
  logic [15:0] work_r [NCH];
  logic [15:0] eff_r [NCH];
  logic [7:0] sp2_act_r, sw_ramp_r;
  cisp_pkg::cisp_src_t sp_src_r [NCH];
  cisp_pkg::cisp_src_t off_src_r [NCH];
  logic [7:0] off_r;
  logic init_r;
  logic [31:0] scan_cnt_r;
  logic scan_tick;

  // shared function levels, gated by configuration codes
  logic par_on, sp_on, off_on;
  always_comb begin
    par_on = term_r.term_a && (ctrl_r[`CISP_CTRL_PCFG] == `CISP_PARAM_CODE);
    sp_on = term_r.term_d && (ctrl_r[`CISP_CTRL_SCFG] == `CISP_SP_CODE);
    off_on = term_r.term_b && (ctrl_r[`CISP_CTRL_OCFG] == `CISP_OFF_CODE);
    if (ctrl_r[`CISP_CTRL_TERM14_SP]) begin
      sp_on = sp_on || (term_r.term_b && (ctrl_r[`CISP_CTRL_OCFG] != `CISP_OFF_CODE));
    end
  end

  // leakage monitor, always live when code matches
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      leak_alarm <= 1'b0;
    end else begin
      leak_alarm <= term_r.term_c && (ctrl_r[`CISP_CTRL_LCFG] == `CISP_LEAK_CODE);
    end
  end

  // scan divider: one enable pulse per controller scan
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      scan_cnt_r <= 32'h00000000;
    end else if (scan_cnt_r >= 32'(SCAN_CYC - 1)) begin
      scan_cnt_r <= 32'h00000000;
    end else begin
      scan_cnt_r <= scan_cnt_r + 32'h00000001;
    end
  end
  assign scan_tick = (scan_cnt_r >= 32'(SCAN_CYC - 1));

  // per channel parameter set distribution
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      param_set_select <= 8'h00;
    end else begin
      for (int c = 0; c < NCH; c++) begin
        param_set_select[c] <= par_on && chcfg_r[c][`CISP_CH_PAR_EN];
      end
    end
  end

  // source ownership for second setpoint and controller off
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      for (int c = 0; c < NCH; c++) begin
        sp_src_r[c] <= cisp_pkg::CISP_SRC_NONE;
        off_src_r[c] <= cisp_pkg::CISP_SRC_NONE;
      end
    end else if (init_r) begin
      // restore from stored host command, then pins by priority
      for (int c = 0; c < NCH; c++) begin
        sp_src_r[c] <= nv_host_sp2[c] ? cisp_pkg::CISP_SRC_HOST : cisp_pkg::CISP_SRC_NONE;
        off_src_r[c] <= nv_host_off[c] ? cisp_pkg::CISP_SRC_HOST : cisp_pkg::CISP_SRC_NONE;
      end
    end else begin
      for (int c = 0; c < NCH; c++) begin
        unique case (sp_src_r[c])
          cisp_pkg::CISP_SRC_NONE: begin
            if (sp_on && chcfg_r[c][`CISP_CH_SP_EN]) begin
              sp_src_r[c] <= cisp_pkg::CISP_SRC_PIN;
            end else if (chcfg_r[c][`CISP_CH_HOST_SP2]) begin
              sp_src_r[c] <= cisp_pkg::CISP_SRC_HOST;
            end
          end
          cisp_pkg::CISP_SRC_PIN: begin
            if (!(sp_on && chcfg_r[c][`CISP_CH_SP_EN])) begin
              sp_src_r[c] <= cisp_pkg::CISP_SRC_NONE;
            end
          end
          cisp_pkg::CISP_SRC_HOST: begin
            if (!chcfg_r[c][`CISP_CH_HOST_SP2]) begin
              sp_src_r[c] <= cisp_pkg::CISP_SRC_NONE;
            end
          end
          default: sp_src_r[c] <= cisp_pkg::CISP_SRC_NONE;
        endcase
        unique case (off_src_r[c])
          cisp_pkg::CISP_SRC_NONE: begin
            if (off_on && chcfg_r[c][`CISP_CH_OFF_EN]) begin
              off_src_r[c] <= cisp_pkg::CISP_SRC_PIN;
            end else if (chcfg_r[c][`CISP_CH_HOST_OFF]) begin
              off_src_r[c] <= cisp_pkg::CISP_SRC_HOST;
            end
          end
          cisp_pkg::CISP_SRC_PIN: begin
            if (!(off_on && chcfg_r[c][`CISP_CH_OFF_EN])) begin
              off_src_r[c] <= cisp_pkg::CISP_SRC_NONE;
            end
          end
          cisp_pkg::CISP_SRC_HOST: begin
            if (!chcfg_r[c][`CISP_CH_HOST_OFF]) begin
              off_src_r[c] <= cisp_pkg::CISP_SRC_NONE;
            end
          end
          default: off_src_r[c] <= cisp_pkg::CISP_SRC_NONE;
        endcase
      end
    end
  end

  // off only masks outputs; setpoint path keeps running
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      chan_off <= 8'h00;
      setpoint_select <= 8'h00;
    end else begin
      for (int c = 0; c < NCH; c++) begin
        chan_off[c] <= (off_src_r[c] != cisp_pkg::CISP_SRC_NONE);
        setpoint_select[c] <= sp2_act_r[c];
      end
    end
  end

  // init flag: one cycle after reset release loads stored values
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      init_r <= 1'b1;
    end else begin
      init_r <= 1'b0;
    end
  end

  // per channel ramp, selection, startup choice and clamp, once per scan
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      sp2_act_r <= 8'h00;
      sw_ramp_r <= 8'h00;
      for (int c = 0; c < NCH; c++) begin
        work_r[c] <= `CISP_SP_RESET;
        eff_r[c] <= `CISP_SP_RESET;
      end
    end else if (init_r) begin
      for (int c = 0; c < NCH; c++) begin
        work_r[c] <= nv_setpoint;
      end
    end else if (scan_tick) begin
      for (int c = 0; c < NCH; c++) begin
        logic want2;
        logic [15:0] tgt, gr, act, pre;
        want2 = (sp_src_r[c] != cisp_pkg::CISP_SRC_NONE);
        tgt = want2 ? ch_r[c].sp2 : ch_r[c].sp1;
        if ((want2 != sp2_act_r[c]) || sw_ramp_r[c]) begin
          gr = ch_r[c].gr_sw;
        end else if (tgt > work_r[c]) begin
          gr = ch_r[c].gr_up;
        end else begin
          gr = ch_r[c].gr_dn;
        end
        act = ramp(work_r[c], tgt, gr);
        work_r[c] <= act;
        sp2_act_r[c] <= want2;
        // switch-over gradient holds until the new target is reached
        sw_ramp_r[c] <= ((want2 != sp2_act_r[c]) || sw_ramp_r[c]) && (act != tgt);
        pre = chcfg_r[c][`CISP_CH_START_SEL] ? ch_r[c].startup : act;
        if (pre < ch_r[c].lo) begin
          eff_r[c] <= ch_r[c].lo;
        end else if (pre > ch_r[c].hi) begin
          eff_r[c] <= ch_r[c].hi;
        end else begin
          eff_r[c] <= pre;
        end
      end
    end
  end

  // axi write path: address and data may come in either order
  logic aw_got_r, w_got_r;
  logic [11:0] aw_r;
  logic [31:0] wd_r;
  logic [3:0] ws_r;
  logic do_wr;
  assign do_wr = aw_got_r && w_got_r && !s_axi_bvalid;
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      aw_r <= 12'h000;
      wd_r <= 32'h00000000;
      ws_r <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else begin
      s_axi_awready <= !aw_got_r && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !w_got_r && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r <= 1'b1;
        aw_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r <= 1'b1;
        wd_r <= s_axi_wdata;
        ws_r <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_r > `CISP_OFF_NVCMD) ? 2'b10 : 2'b00;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // register writes; stored second setpoint restored at start
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ctrl_r <= 32'h00000000;
      chsel_r <= 3'h0;
      for (int c = 0; c < NCH; c++) begin
        chcfg_r[c] <= 8'h00;
        ch_r[c] <= '0;
        ch_r[c].hi <= `CISP_HI_RESET;
      end
    end else if (init_r) begin
      for (int c = 0; c < NCH; c++) begin
        ch_r[c].sp1 <= nv_setpoint;
        ch_r[c].sp2 <= nv_second_setpoint;
        chcfg_r[c][`CISP_CH_HOST_SP2] <= nv_host_sp2[c];
        chcfg_r[c][`CISP_CH_HOST_OFF] <= nv_host_off[c];
      end
    end else if (do_wr) begin
      unique case (aw_r)
        `CISP_OFF_CTRL: ctrl_r <= merge(ctrl_r, wd_r, ws_r);
        `CISP_OFF_CHSEL: chsel_r <= ws_r[0] ? wd_r[2:0] : chsel_r;
        `CISP_OFF_CHCFG: chcfg_r[chsel_r] <= ws_r[0] ? wd_r[7:0] : chcfg_r[chsel_r];
        `CISP_OFF_SP1: ch_r[chsel_r].sp1 <= 16'(merge({16'h0000, ch_r[chsel_r].sp1}, wd_r, ws_r));
        `CISP_OFF_SP2: ch_r[chsel_r].sp2 <= 16'(merge({16'h0000, ch_r[chsel_r].sp2}, wd_r, ws_r));
        `CISP_OFF_GRUP: ch_r[chsel_r].gr_up <= 16'(merge({16'h0000, ch_r[chsel_r].gr_up}, wd_r, ws_r));
        `CISP_OFF_GRDN: ch_r[chsel_r].gr_dn <= 16'(merge({16'h0000, ch_r[chsel_r].gr_dn}, wd_r, ws_r));
        `CISP_OFF_GRSW: ch_r[chsel_r].gr_sw <= 16'(merge({16'h0000, ch_r[chsel_r].gr_sw}, wd_r, ws_r));
        `CISP_OFF_LOLIM: ch_r[chsel_r].lo <= 16'(merge({16'h0000, ch_r[chsel_r].lo}, wd_r, ws_r));
        `CISP_OFF_HILIM: ch_r[chsel_r].hi <= 16'(merge({16'h0000, ch_r[chsel_r].hi}, wd_r, ws_r));
        `CISP_OFF_STARTUP: ch_r[chsel_r].startup <= 16'(merge({16'h0000, ch_r[chsel_r].startup}, wd_r, ws_r));
        default: ;
      endcase
    end
  end

  // axi read path: one cycle accept, data next cycle
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h00000000;
    unique case (s_axi_araddr)
      `CISP_OFF_CTRL: rd_mux = ctrl_r;
      `CISP_OFF_STATUS: rd_mux = {8'h00, chan_off, setpoint_select, param_set_select};
      `CISP_OFF_CHSEL: rd_mux = {29'h00000000, chsel_r};
      `CISP_OFF_CHCFG: rd_mux = {24'h000000, chcfg_r[chsel_r]};
      `CISP_OFF_SP1: rd_mux = {16'h0000, ch_r[chsel_r].sp1};
      `CISP_OFF_SP2: rd_mux = {16'h0000, ch_r[chsel_r].sp2};
      `CISP_OFF_GRUP: rd_mux = {16'h0000, ch_r[chsel_r].gr_up};
      `CISP_OFF_GRDN: rd_mux = {16'h0000, ch_r[chsel_r].gr_dn};
      `CISP_OFF_GRSW: rd_mux = {16'h0000, ch_r[chsel_r].gr_sw};
      `CISP_OFF_LOLIM: rd_mux = {16'h0000, ch_r[chsel_r].lo};
      `CISP_OFF_HILIM: rd_mux = {16'h0000, ch_r[chsel_r].hi};
      `CISP_OFF_EFFSP: rd_mux = {work_r[chsel_r], eff_r[chsel_r]};
      `CISP_OFF_STARTUP: rd_mux = {16'h0000, ch_r[chsel_r].startup};
      `CISP_OFF_NVCMD: rd_mux = {11'h000, leak_alarm, term_r, 16'h0000};
      default: rd_mux = 32'h00000000;
    endcase
  end
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'b00;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= (s_axi_araddr > `CISP_OFF_NVCMD) ? 2'b10 : 2'b00;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

/* File: rtl/cisp_cfg.svh */
`ifndef CISP_CFG_SVH
`define CISP_CFG_SVH
// register byte offsets
`define CISP_OFF_CTRL 12'h000
`define CISP_OFF_STATUS 12'h004
`define CISP_OFF_CHSEL 12'h008
`define CISP_OFF_CHCFG 12'h00C
`define CISP_OFF_SP1 12'h010
`define CISP_OFF_SP2 12'h014
`define CISP_OFF_GRUP 12'h018
`define CISP_OFF_GRDN 12'h01C
`define CISP_OFF_GRSW 12'h020
`define CISP_OFF_LOLIM 12'h024
`define CISP_OFF_HILIM 12'h028
`define CISP_OFF_EFFSP 12'h02C
`define CISP_OFF_STARTUP 12'h030
`define CISP_OFF_NVCMD 12'h034
// configuration codes that enable each shared terminal
`define CISP_PARAM_CODE 4'h3
`define CISP_SP_CODE 4'h1
`define CISP_OFF_CODE 4'h1
`define CISP_LEAK_CODE 4'h4
// ctrl register fields
`define CISP_CTRL_PCFG 3:0
`define CISP_CTRL_SCFG 7:4
`define CISP_CTRL_OCFG 11:8
`define CISP_CTRL_LCFG 15:12
`define CISP_CTRL_TERM14_SP 16
// per channel config fields
`define CISP_CH_PAR_EN 0
`define CISP_CH_SP_EN 1
`define CISP_CH_OFF_EN 2
`define CISP_CH_HOST_SP2 3
`define CISP_CH_HOST_OFF 4
`define CISP_CH_START_SEL 5
// scan period in ns: one channel pass per 500 ms
`define CISP_SCAN_NS 500000000
`define CISP_CLK_NS 8
`define CISP_SCAN_CYC (`CISP_SCAN_NS / `CISP_CLK_NS)
`define CISP_SP_RESET 16'h0000
`define CISP_HI_RESET 16'hFFFF
`endif

/* File: rtl/cisp_pkg.sv */
package cisp_pkg;
  // source that switched a state on
  typedef enum logic [1:0] {
    CISP_SRC_NONE = 2'b00,
    CISP_SRC_PIN = 2'b01,
    CISP_SRC_HOST = 2'b10
  } cisp_src_t;
  // per channel setpoint data
  typedef struct packed {
    logic [15:0] sp1;
    logic [15:0] sp2;
    logic [15:0] gr_up;
    logic [15:0] gr_dn;
    logic [15:0] gr_sw;
    logic [15:0] lo;
    logic [15:0] hi;
    logic [15:0] startup;
  } cisp_chan_t;
  // conditioned shared terminals
  typedef struct packed {
    logic term_a;
    logic term_b;
    logic term_c;
    logic term_d;
  } cisp_term_t;
endpackage

/* File: sim/cisp_assertions.sv */
`timescale 1ns/100ps
`default_nettype none
module cisp_assertions (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // shared terminals and results
  input wire logic shared_terminal_a,
  input wire logic shared_terminal_c,
  input wire logic [7:0] param_set_select,
  input wire logic [7:0] setpoint_select,
  input wire logic [7:0] chan_off,
  input wire logic leak_alarm,
  // register bus
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  logic wr_bad_r;
  logic rd_bad_r;
  default clocking dflt @(posedge ref_clk);
  endclocking
  default disable iff (reset);
  // remember whether the accepted address lies past the map
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      wr_bad_r <= 1'h0;
      rd_bad_r <= 1'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) wr_bad_r <= (s_axi_awaddr > 12'h034);
      if (s_axi_arvalid && s_axi_arready) rd_bad_r <= (s_axi_araddr > 12'h034);
    end
  end
  // transfer steps
  sequence rd_take_s;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence wr_take_s;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  out_reset_a: assert property ($fell(reset) |-> param_set_select == 8'h00 && chan_off == 8'h00
    && setpoint_select == 8'h00 && !leak_alarm) else $error("outputs not cleared by reset");
  aw_pulse_a: assert property (s_axi_awready |-> $past(s_axi_awvalid) && !$past(s_axi_awready))
    else $error("address ready without request");
  wr_answer_a: assert property (wr_take_s |-> ##[1:3] s_axi_bvalid) else $error("write answer late");
  wr_resp_a: assert property (s_axi_bvalid |-> s_axi_bresp == (wr_bad_r ? 2'h2 : 2'h0))
    else $error("write response wrong");
  rd_resp_a: assert property (rd_take_s |=> s_axi_rvalid && s_axi_rresp == (rd_bad_r ? 2'h2 : 2'h0)
    && (!rd_bad_r || s_axi_rdata == 32'h0)) else $error("read answer wrong");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  param_idle_a: assert property (!shared_terminal_a [*8] |-> param_set_select == 8'h00)
    else $error("parameter set 2 without input");
  leak_idle_a: assert property (!shared_terminal_c [*8] |-> !leak_alarm)
    else $error("leak flag without input");
endmodule
bind cisp_top cisp_assertions cisp_assertions_i (
  .ref_clk, .reset, .shared_terminal_a, .shared_terminal_c, .param_set_select, .setpoint_select,
  .chan_off, .leak_alarm, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
);
`default_nettype wire

/* File: sim/cisp_field_model.sv */
`timescale 1ns/100ps
`default_nettype none
module cisp_field_model #(
  parameter int RELAY_CYC = 4
) (
  // clock
  input wire logic ref_clk,
  // contact and fault commands
  input wire logic contact_a,
  input wire logic contact_b,
  input wire logic contact_d,
  input wire logic leak_fault,
  // field lines
  output logic shared_terminal_a,
  output logic shared_terminal_b,
  output logic shared_terminal_c,
  output logic shared_terminal_d
);
  logic [RELAY_CYC-1:0] relay_r = '0;
  // relay trips a few cycles after the fault, far inside its response limit
  always_ff @(posedge ref_clk) begin
    relay_r <= {relay_r[RELAY_CYC-2:0], leak_fault};
  end
  // open contacts leave each line at its pull-down level
  assign shared_terminal_a = contact_a;
  assign shared_terminal_b = contact_b;
  assign shared_terminal_c = relay_r[RELAY_CYC-1];
  assign shared_terminal_d = contact_d;
endmodule
`default_nettype wire

/* File: sim/tb_cisp_top.sv */
`timescale 1ns/100ps
`default_nettype none
`include "cisp_cfg.svh"
module tb_cisp_top;
  typedef struct packed {
    logic [3:0] pins;
    logic [7:0] par;
    logic [7:0] sel;
    logic [7:0] off;
    logic leak;
  } cisp_row_t;
  // pins {a,b,c,d} beside the outputs they give
  cisp_row_t rows [7] = '{'{4'h0, 8'h00, 8'h00, 8'h80, 1'h0}, '{4'h8, 8'h7F, 8'h00, 8'h80, 1'h0},
    '{4'h4, 8'h00, 8'h00, 8'hFF, 1'h0}, '{4'h2, 8'h00, 8'h00, 8'h80, 1'h1},
    '{4'h1, 8'h00, 8'h7E, 8'h80, 1'h0}, '{4'hF, 8'h7F, 8'h7E, 8'hFF, 1'h1},
    '{4'h0, 8'h00, 8'h00, 8'h80, 1'h0}};
  logic ref_clk = 1'h0;
  logic reset = 1'h1;
  logic fld_a = 1'h0, fld_b = 1'h0, fld_d = 1'h0, leak_fault = 1'h0;
  logic shared_terminal_a, shared_terminal_b, shared_terminal_c, shared_terminal_d;
  logic [15:0] nv_setpoint = 16'h0100, nv_second_setpoint = 16'h0200;
  logic [7:0] nv_host_sp2 = 8'h00, nv_host_off = 8'h80;
  logic [7:0] param_set_select, setpoint_select, chan_off;
  logic leak_alarm;
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [31:0] s_axi_rdata, rdat;
  int err_count = 0, samples_checked = 0, cyc = 0;
  cisp_top #(.NCH(8), .SCAN_CYC(8)) cisp_top_i (.ref_clk, .reset, .shared_terminal_a, .shared_terminal_b,
    .shared_terminal_c, .shared_terminal_d, .nv_setpoint, .nv_second_setpoint, .nv_host_sp2, .nv_host_off,
    .param_set_select, .setpoint_select, .chan_off, .leak_alarm, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  cisp_field_model #(.RELAY_CYC(4)) cisp_field_model_i (.ref_clk, .contact_a(fld_a), .contact_b(fld_b),
    .contact_d(fld_d), .leak_fault, .shared_terminal_a, .shared_terminal_b, .shared_terminal_c, .shared_terminal_d);
  // clock: invert every half period
  always #4 ref_clk = ~ref_clk;
  // cut a hung run short
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      err_count++;
      $display("timeout");
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("checked %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  // write: both channels and bready offered together, response taken at the bvalid edge
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    resp = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask
  // read: rready offered with the address, data taken at the rvalid edge
  task automatic axi_rd(input logic [11:0] a);
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    rdat = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask
  // main sequence
  initial begin
    repeat (4) @(posedge ref_clk);
    reset <= 1'h0;
    repeat (4) @(posedge ref_clk);
    chk("chan_off", 32'h80, chan_off);
    axi_rd(`CISP_OFF_EFFSP);
    chk("working", 32'h0100, rdat[31:16]);
    axi_rd(`CISP_OFF_HILIM);
    chk("hi limit", 32'hFFFF, rdat[15:0]);
    axi_rd(`CISP_OFF_LOLIM);
    chk("lo limit", 32'h0, rdat[15:0]);
    $display("power-up test done");
    axi_wr(`CISP_OFF_CTRL, 32'h0000_4113);
    for (int i = 0; i < 8; i++) begin
      axi_wr(`CISP_OFF_CHSEL, 32'(i));
      axi_wr(`CISP_OFF_CHCFG, (i == 0) ? 32'h05 : (i == 7) ? 32'h10 : 32'h07);
    end
    for (int r = 0; r < 7; r++) begin
      @(posedge ref_clk);
      {fld_a, fld_b, leak_fault, fld_d} <= rows[r].pins;
      repeat (40) @(posedge ref_clk);
      chk("param_set_select", rows[r].par, param_set_select);
      chk("setpoint_select", rows[r].sel, setpoint_select);
      chk("chan_off", rows[r].off, chan_off);
      chk("leak_alarm", rows[r].leak, leak_alarm);
    end
    $display("terminal table done");
    fld_b <= 1'h1;
    axi_wr(`CISP_OFF_CHSEL, 32'h3);
    axi_wr(`CISP_OFF_CHCFG, 32'h17);
    axi_wr(`CISP_OFF_CHCFG, 32'h07);
    repeat (10) @(posedge ref_clk);
    chk("pin owned off", 32'h1, chan_off[3]);
    fld_b <= 1'h0;
    axi_wr(`CISP_OFF_CHSEL, 32'h2);
    axi_wr(`CISP_OFF_CHCFG, 32'h17);
    fld_b <= 1'h1;
    repeat (20) @(posedge ref_clk);
    fld_b <= 1'h0;
    repeat (20) @(posedge ref_clk);
    chk("host owned off", 32'h84, chan_off);
    axi_wr(`CISP_OFF_CHCFG, 32'h07);
    repeat (10) @(posedge ref_clk);
    chk("host release", 32'h80, chan_off);
    $display("ownership test done");
    axi_wr(`CISP_OFF_CHSEL, 32'h0);
    axi_wr(`CISP_OFF_GRUP, 32'h20);
    axi_wr(`CISP_OFF_GRDN, 32'h0C);
    axi_wr(`CISP_OFF_GRSW, 32'h08);
    axi_wr(`CISP_OFF_SP1, 32'h0180);
    repeat (20) @(posedge ref_clk);
    axi_rd(`CISP_OFF_EFFSP);
    chk("rising ramp", 32'h1, rdat[31:16] > 16'h0100 && rdat[31:16] < 16'h0180);
    repeat (40) @(posedge ref_clk);
    axi_rd(`CISP_OFF_EFFSP);
    chk("rising end", 32'h0180, rdat[31:16]);
    axi_wr(`CISP_OFF_SP1, 32'h0100);
    repeat (20) @(posedge ref_clk);
    axi_rd(`CISP_OFF_EFFSP);
    chk("falling ramp", 32'h1, rdat[31:16] > 16'h0100 && rdat[31:16] < 16'h0180);
    repeat (100) @(posedge ref_clk);
    axi_rd(`CISP_OFF_EFFSP);
    chk("falling end", 32'h0100, rdat[31:16]);
    fld_d <= 1'h1;
    axi_wr(`CISP_OFF_CHCFG, 32'h07);
    repeat (20) @(posedge ref_clk);
    axi_rd(`CISP_OFF_EFFSP);
    chk("switch ramp", 32'h1, rdat[31:16] > 16'h0100 && rdat[31:16] <= 16'h0118);
    chk("second active", 32'h1, setpoint_select[0]);
    fld_b <= 1'h1;
    axi_wr(`CISP_OFF_HILIM, 32'h0180);
    repeat (300) @(posedge ref_clk);
    axi_rd(`CISP_OFF_EFFSP);
    chk("clamped", 32'h0180, rdat[15:0]);
    chk("working off", 32'h0200, rdat[31:16]);
    chk("off while ramping", 32'h1, chan_off[0]);
    $display("setpoint test done");
    axi_wr(`CISP_OFF_STARTUP, 32'h0150);
    axi_wr(`CISP_OFF_CHCFG, 32'h27);
    repeat (20) @(posedge ref_clk);
    axi_rd(`CISP_OFF_EFFSP);
    chk("startup value", 32'h0150, rdat[15:0]);
    axi_wr(`CISP_OFF_CTRL, 32'h0001_4013);
    fld_d <= 1'h0;
    repeat (20) @(posedge ref_clk);
    chk("terminal b switch", 32'h1, setpoint_select[0]);
    $display("startup and terminal b test done");
    axi_wr(12'h040, 32'hFFFF_FFFF);
    chk("bresp", 32'h2, resp);
    axi_rd(12'h040);
    chk("rresp", 32'h2, resp);
    chk("rdata", 32'h0, rdat);
    $display("unmapped test done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
